// ===== core/fmb_hyst_flag.sv
`timescale 1ns/1ps
module fmb_hyst_flag #(
  parameter int W = 12,
  parameter bit SET_WHEN_ABOVE = 1'b1
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic [W-1:0] value_in,
  input wire logic [W-1:0] set_level_in,
  input wire logic [W-1:0] clear_level_in,
  input wire logic force_in,
  output logic flag_out
);

  logic flag_nxt;

  // Between the two levels the flag holds: that is the hysteresis
  always_comb begin
    flag_nxt = flag_out;
    if (SET_WHEN_ABOVE) begin
      if (force_in || value_in > set_level_in) begin
        flag_nxt = 1'b1;
      end else if (value_in < clear_level_in) begin
        flag_nxt = 1'b0;
      end
    end else begin
      if (force_in || value_in < set_level_in) begin
        flag_nxt = 1'b1;
      end else if (value_in > clear_level_in) begin
        flag_nxt = 1'b0;
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      flag_out <= 1'b0;
    end else begin
      flag_out <= flag_nxt;
    end
  end

endmodule // fmb_hyst_flag

// ===== core/fmb_pkg.sv
// What this block does
// RQ1: Low-battery warning bit 2 set below threshold select, cleared above it.
// RQ2: Thermal shutdown bit 1 sets above 156.5 C or rail fault; clears below 132.5 C.
// RQ3: Thermal warning bit 0 sets above 123.4 C, clears below 121.4 C.
// RQ4: Interrupt mask register sits at 0x0D and resets to f5.
// RQ5: Mask bit n gates status bit n; zero lets it interrupt, one masks.
// RQ6: Read/write dead-time register sits at 0x0E and resets to 00.
// RQ7: Dead time code 0 is zero, code 1 is 333 ns, 111 ns per step.
// RQ8: Read/write quick shutoff timing register sits at 0x0F, resets to 07.
// RQ9: Read-only main status at 0x0C resets to 00; bits 7..3 report upper faults.
// RQ10: Interrupt output is high while any unmasked status flag is set.
package fmb_pkg;

  ////////////////////////////////////////////////////////////////////////////////
  // Register map
  localparam logic [6:0] ADDR_MAIN_STATUS = 7'h0c;
  localparam logic [6:0] ADDR_INTERRUPT_MASK = 7'h0d;
  localparam logic [6:0] ADDR_SWITCH_DEAD_TIME = 7'h0e;
  localparam logic [6:0] ADDR_QUICK_SHUTOFF_TIMING = 7'h0f;
  localparam logic [7:0] RST_MAIN_STATUS = 8'h00;
  localparam logic [7:0] RST_INTERRUPT_MASK = 8'hf5;
  localparam logic [7:0] RST_SWITCH_DEAD_TIME = 8'h00;
  localparam logic [7:0] RST_QUICK_SHUTOFF_TIMING = 8'h07;
  localparam logic [7:0] READ_UNMAPPED = 8'h00;

  ////////////////////////////////////////////////////////////////////////////////
  // Serial frame: command byte {write, addr[6:0]} then one data byte, MSB first
  localparam int FRAME_CMD_BITS = 8;
  localparam int FRAME_BITS = 16;
  localparam int CMD_WRITE_POS = 7;

  ////////////////////////////////////////////////////////////////////////////////
  // Temperatures in tenths of a degree C
  localparam int TEMP_W = 12;
  localparam logic [11:0] TEMP_SHUT_SET = 12'h61d;   // 156.5 C
  localparam logic [11:0] TEMP_SHUT_CLEAR = 12'h52d; // 132.5 C
  localparam logic [11:0] TEMP_WARN_SET = 12'h4d2;   // 123.4 C
  localparam logic [11:0] TEMP_WARN_CLEAR = 12'h4be; // 121.4 C

  ////////////////////////////////////////////////////////////////////////////////
  // Dead-time timing, all in ns
  localparam int CLK_PERIOD_NS = 50;
  localparam int DEAD_STEP_NS = 111;
  localparam int DEAD_CODE1_NS = 333;
  localparam int DEAD_BASE_NS = DEAD_CODE1_NS - DEAD_STEP_NS;
  localparam int DEAD_NS_W = 15;
  localparam logic [14:0] DEAD_STEP_NS_V = DEAD_STEP_NS[14:0];
  localparam logic [14:0] DEAD_BASE_NS_V = DEAD_BASE_NS[14:0];
  localparam logic [14:0] CLK_PERIOD_NS_V = CLK_PERIOD_NS[14:0];

  typedef struct packed {
    logic supply_fault;
    logic illumination_fault_flag;
    logic projector_on_change_flag;
    logic micromirror_fault_flag;
    logic low_battery_shutdown_flag;
    logic low_battery_warning;
    logic thermal_shutdown_flag;
    logic thermal_warning_flag;
  } fmb_status_s;

  typedef enum {FMB_SW_STEADY, FMB_SW_GAP} fmb_sw_state_e;

endpackage

// ===== core/fmb_regs.sv
`timescale 1ns/1ps
module fmb_regs #(
  parameter int SUPPLY_W = 8,
  parameter int NUM_SW = 3
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  // Serial register port, mode 0
  input wire logic spi_clk_in,
  input wire logic spi_cs_n_in,
  input wire logic spi_mosi_in,
  output logic spi_miso_out,
  // Monitored conditions
  input wire logic [fmb_pkg::TEMP_W-1:0] die_temp_in,
  input wire logic internal_five_volt_rail_fault_in,
  input wire logic [SUPPLY_W-1:0] input_supply_in,
  input wire logic [SUPPLY_W-1:0] low_battery_threshold_select_in,
  input wire logic supply_fault_in,
  input wire logic illumination_fault_in,
  input wire logic projector_on_in,
  input wire logic micromirror_fault_in,
  input wire logic low_battery_shutdown_in,
  // Light-source switches
  input wire logic [NUM_SW-1:0] switch_request_in,
  output logic [NUM_SW-1:0] switch_drive_out,
  output logic [7:0] quick_shutoff_timing_out,
  output logic irq_out
);

  ////////////////////////////////////////////////////////////////////////////////
  // Status flags
  logic low_battery_warning;
  logic thermal_shutdown_flag;
  logic thermal_warning_flag;
  fmb_pkg::fmb_status_s status_r;
  fmb_pkg::fmb_status_s status_nxt;

  fmb_hyst_flag #(.W(SUPPLY_W), .SET_WHEN_ABOVE(1'b0)) u_low_batt (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .value_in(input_supply_in),
    .set_level_in(low_battery_threshold_select_in),
    .clear_level_in(low_battery_threshold_select_in),
    .force_in(1'b0),
    .flag_out(low_battery_warning)
  ); // RQ1

  fmb_hyst_flag #(.W(fmb_pkg::TEMP_W), .SET_WHEN_ABOVE(1'b1)) u_therm_shut (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .value_in(die_temp_in),
    .set_level_in(fmb_pkg::TEMP_SHUT_SET),
    .clear_level_in(fmb_pkg::TEMP_SHUT_CLEAR),
    .force_in(internal_five_volt_rail_fault_in),
    .flag_out(thermal_shutdown_flag)
  ); // RQ2

  fmb_hyst_flag #(.W(fmb_pkg::TEMP_W), .SET_WHEN_ABOVE(1'b1)) u_therm_warn (
    .clk_in(clk_in),
    .rst_n_in(rst_n_in),
    .value_in(die_temp_in),
    .set_level_in(fmb_pkg::TEMP_WARN_SET),
    .clear_level_in(fmb_pkg::TEMP_WARN_CLEAR),
    .force_in(1'b0),
    .flag_out(thermal_warning_flag)
  ); // RQ3

  always_comb begin
    status_nxt.supply_fault = supply_fault_in; // RQ9
    status_nxt.illumination_fault_flag = illumination_fault_in; // RQ9
    // Flag reports the projector-on pin being low
    status_nxt.projector_on_change_flag = ~projector_on_in; // RQ9
    status_nxt.micromirror_fault_flag = micromirror_fault_in; // RQ9
    status_nxt.low_battery_shutdown_flag = low_battery_shutdown_in; // RQ9
    status_nxt.low_battery_warning = low_battery_warning;
    status_nxt.thermal_shutdown_flag = thermal_shutdown_flag;
    status_nxt.thermal_warning_flag = thermal_warning_flag;
  end

  // Registered so the read mux sees flops, not pin levels
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      status_r <= fmb_pkg::RST_MAIN_STATUS; // RQ9
    end else begin
      status_r <= status_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Serial port and registers
  logic sclk_prev_r;
  logic sclk_prev_nxt;
  logic [4:0] bit_cnt_r;
  logic [4:0] bit_cnt_nxt;
  logic [7:0] rx_r;
  logic [7:0] rx_nxt;
  logic [7:0] cmd_r;
  logic [7:0] cmd_nxt;
  logic [7:0] tx_r;
  logic [7:0] tx_nxt;
  logic miso_r;
  logic miso_nxt;
  logic [7:0] interrupt_mask_r;
  logic [7:0] interrupt_mask_nxt;
  logic [7:0] switch_dead_time_r;
  logic [7:0] switch_dead_time_nxt;
  logic [7:0] quick_shutoff_timing_r;
  logic [7:0] quick_shutoff_timing_nxt;
  logic irq_r;
  logic irq_nxt;
  logic sclk_rise;
  logic sclk_fall;
  logic [7:0] rd_data;
  logic [7:0] wr_data;
  logic [6:0] addr;

  assign sclk_rise = spi_clk_in & ~sclk_prev_r;
  assign sclk_fall = ~spi_clk_in & sclk_prev_r;

  always_comb begin
    addr = rx_r[6:0];
    // Unmapped addresses read as zero and ignore writes
    if (addr == fmb_pkg::ADDR_MAIN_STATUS) begin
      rd_data = status_r; // RQ9
    end else if (addr == fmb_pkg::ADDR_INTERRUPT_MASK) begin
      rd_data = interrupt_mask_r;
    end else if (addr == fmb_pkg::ADDR_SWITCH_DEAD_TIME) begin
      rd_data = switch_dead_time_r;
    end else if (addr == fmb_pkg::ADDR_QUICK_SHUTOFF_TIMING) begin
      rd_data = quick_shutoff_timing_r;
    end else begin
      rd_data = fmb_pkg::READ_UNMAPPED;
    end
  end

  always_comb begin
    sclk_prev_nxt = spi_clk_in;
    bit_cnt_nxt = bit_cnt_r;
    rx_nxt = rx_r;
    cmd_nxt = cmd_r;
    tx_nxt = tx_r;
    miso_nxt = miso_r;
    interrupt_mask_nxt = interrupt_mask_r;
    switch_dead_time_nxt = switch_dead_time_r;
    quick_shutoff_timing_nxt = quick_shutoff_timing_r;
    wr_data = {rx_r[6:0], spi_mosi_in};
    if (spi_cs_n_in) begin
      // Deselect aborts any partial frame
      bit_cnt_nxt = 5'h00;
      miso_nxt = 1'b0;
    end else if (sclk_rise && bit_cnt_r < 5'(fmb_pkg::FRAME_BITS)) begin
      rx_nxt = wr_data;
      bit_cnt_nxt = bit_cnt_r + 5'h01;
      if (bit_cnt_r == 5'(fmb_pkg::FRAME_CMD_BITS - 1)) begin
        cmd_nxt = wr_data;
      end
      if (bit_cnt_r == 5'(fmb_pkg::FRAME_BITS - 1) && cmd_r[fmb_pkg::CMD_WRITE_POS]) begin
        if (cmd_r[6:0] == fmb_pkg::ADDR_INTERRUPT_MASK) begin
          interrupt_mask_nxt = wr_data; // RQ4
        end else if (cmd_r[6:0] == fmb_pkg::ADDR_SWITCH_DEAD_TIME) begin
          switch_dead_time_nxt = wr_data; // RQ6
        end else if (cmd_r[6:0] == fmb_pkg::ADDR_QUICK_SHUTOFF_TIMING) begin
          quick_shutoff_timing_nxt = wr_data; // RQ8
        end
      end
    end else if (sclk_fall && bit_cnt_r >= 5'(fmb_pkg::FRAME_CMD_BITS)
                 && bit_cnt_r < 5'(fmb_pkg::FRAME_BITS)) begin
      // Data byte is fetched at the first falling edge after the command
      if (bit_cnt_r == 5'(fmb_pkg::FRAME_CMD_BITS)) begin
        miso_nxt = rd_data[7];
        tx_nxt = {rd_data[6:0], 1'b0};
      end else begin
        miso_nxt = tx_r[7];
        tx_nxt = {tx_r[6:0], 1'b0};
      end
    end
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sclk_prev_r <= 1'b0;
      bit_cnt_r <= 5'h00;
      rx_r <= 8'h00;
      cmd_r <= 8'h00;
      tx_r <= 8'h00;
      miso_r <= 1'b0;
      interrupt_mask_r <= fmb_pkg::RST_INTERRUPT_MASK; // RQ4
      switch_dead_time_r <= fmb_pkg::RST_SWITCH_DEAD_TIME; // RQ6
      quick_shutoff_timing_r <= fmb_pkg::RST_QUICK_SHUTOFF_TIMING; // RQ8
    end else begin
      sclk_prev_r <= sclk_prev_nxt;
      bit_cnt_r <= bit_cnt_nxt;
      rx_r <= rx_nxt;
      cmd_r <= cmd_nxt;
      tx_r <= tx_nxt;
      miso_r <= miso_nxt;
      interrupt_mask_r <= interrupt_mask_nxt;
      switch_dead_time_r <= switch_dead_time_nxt;
      quick_shutoff_timing_r <= quick_shutoff_timing_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Interrupt request
  // Level, not latched: a flag that clears withdraws the request
  always_comb begin
    irq_nxt = |(status_r & ~interrupt_mask_r); // RQ5 RQ10
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      irq_r <= 1'b0;
    end else begin
      irq_r <= irq_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Break-before-make sequencer
  fmb_pkg::fmb_sw_state_e sw_state_r;
  fmb_pkg::fmb_sw_state_e sw_state_nxt;
  logic [NUM_SW-1:0] drive_r;
  logic [NUM_SW-1:0] drive_nxt;
  logic [NUM_SW-1:0] target_r;
  logic [NUM_SW-1:0] target_nxt;
  logic [fmb_pkg::DEAD_NS_W-1:0] elapsed_ns_r;
  logic [fmb_pkg::DEAD_NS_W-1:0] elapsed_ns_nxt;
  logic [fmb_pkg::DEAD_NS_W-1:0] dead_ns;

  // Code n gives 222 + 111*n ns; counting in ns rounds the gap up to whole clocks
  always_comb begin
    dead_ns = fmb_pkg::DEAD_BASE_NS_V
              + 15'(switch_dead_time_r) * fmb_pkg::DEAD_STEP_NS_V; // RQ7
  end

  always_comb begin
    sw_state_nxt = sw_state_r;
    drive_nxt = drive_r;
    target_nxt = target_r;
    elapsed_ns_nxt = elapsed_ns_r;
    case (sw_state_r)
      fmb_pkg::FMB_SW_STEADY: begin
        if (switch_request_in != target_r) begin
          target_nxt = switch_request_in;
          if (switch_dead_time_r == 8'h00) begin
            drive_nxt = switch_request_in; // RQ7
          end else begin
            // Break first: every switch opens before the new one closes
            drive_nxt = '0;
            elapsed_ns_nxt = fmb_pkg::CLK_PERIOD_NS_V;
            sw_state_nxt = fmb_pkg::FMB_SW_GAP;
          end
        end
      end
      fmb_pkg::FMB_SW_GAP: begin
        drive_nxt = '0;
        if (switch_dead_time_r == 8'h00) begin
          // Code cleared mid-gap: zero dead time ends the gap at once
          target_nxt = switch_request_in;
          drive_nxt = switch_request_in; // RQ7
          sw_state_nxt = fmb_pkg::FMB_SW_STEADY;
        end else if (switch_request_in != target_r) begin
          // Request moved mid-gap: restart the full gap
          target_nxt = switch_request_in;
          elapsed_ns_nxt = fmb_pkg::CLK_PERIOD_NS_V;
        end else if (elapsed_ns_r >= dead_ns) begin
          drive_nxt = target_r; // RQ7
          sw_state_nxt = fmb_pkg::FMB_SW_STEADY;
        end else begin
          elapsed_ns_nxt = elapsed_ns_r + fmb_pkg::CLK_PERIOD_NS_V;
        end
      end
      default: begin
        drive_nxt = '0;
        sw_state_nxt = fmb_pkg::FMB_SW_STEADY;
      end
    endcase
  end

  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sw_state_r <= fmb_pkg::FMB_SW_STEADY;
      drive_r <= '0;
      target_r <= '0;
      elapsed_ns_r <= '0;
    end else begin
      sw_state_r <= sw_state_nxt;
      drive_r <= drive_nxt;
      target_r <= target_nxt;
      elapsed_ns_r <= elapsed_ns_nxt;
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // Outputs
  assign spi_miso_out = miso_r;
  assign switch_drive_out = drive_r;
  assign quick_shutoff_timing_out = quick_shutoff_timing_r;
  assign irq_out = irq_r;

endmodule // fmb_regs

// ===== sim/fmb_host.sv
`timescale 1ns/1ps
module fmb_host (
  input wire logic clk_in,
  input wire logic spi_miso_in,
  output logic spi_clk_out,
  output logic spi_cs_n_out,
  output logic spi_mosi_out
);
  initial begin
    spi_clk_out <= 1'b0;
    spi_cs_n_out <= 1'b1;
    spi_mosi_out <= 1'b0;
  end
  // Long levels: the port oversamples the serial clock
  task automatic xfer(input logic [15:0] fr, input int nbits, output logic [7:0] rd);
    rd = 8'h00;
    @(posedge clk_in);
    spi_cs_n_out <= 1'b0;
    for (int i = 0; i < nbits; i++) begin
      spi_mosi_out <= fr[15-i];
      repeat (6) @(posedge clk_in);
      rd = {rd[6:0], spi_miso_in};
      spi_clk_out <= 1'b1;
      repeat (4) @(posedge clk_in);
      spi_clk_out <= 1'b0;
    end
    repeat (4) @(posedge clk_in);
    spi_cs_n_out <= 1'b1;
    spi_mosi_out <= ~spi_mosi_out; // Idle line shows junk, not the last bit
    repeat (4) @(posedge clk_in);
  endtask
endmodule // fmb_host

// ===== sim/fmb_regs_checker.sv
`timescale 1ns/1ps
module fmb_regs_checker #(
  parameter int SUPPLY_W = 8,
  parameter int NUM_SW = 3
) (
  input wire logic clk_in,
  input wire logic rst_n_in,
  input wire logic spi_clk_in,
  input wire logic spi_cs_n_in,
  input wire logic spi_mosi_in,
  input wire logic spi_miso_out,
  input wire logic [NUM_SW-1:0] switch_request_in,
  input wire logic [NUM_SW-1:0] switch_drive_out,
  input wire logic [7:0] quick_shutoff_timing_out,
  input wire logic irq_out
);
  default clocking cb @(posedge clk_in); endclocking
  default disable iff (!rst_n_in);
  ////////////////////////////////////////////////////////////////////////////////
  // Shadow of host writes; commits on the same clk edge as the design
  logic sck_r;
  logic [4:0] cnt_r;
  logic [14:0] sh_r;
  logic [7:0] dead_r, qd_r;
  logic [2:0] qwin_r;
  logic rise, cm;
  logic [15:0] fr;
  assign rise = spi_clk_in && !sck_r && !spi_cs_n_in;
  assign fr = {sh_r, spi_mosi_in};
  assign cm = rise && cnt_r == 5'h0f && fr[15];
  always_ff @(posedge clk_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sck_r <= 1'b0;
      cnt_r <= 5'h00;
      dead_r <= 8'h00;
      qd_r <= 8'h07;
      qwin_r <= 3'h0;
    end else begin
      sck_r <= spi_clk_in;
      qwin_r <= (qwin_r != 3'h0) ? qwin_r - 3'h1 : 3'h0;
      if (spi_cs_n_in) cnt_r <= 5'h00;
      else if (rise && cnt_r != 5'h10) begin
        cnt_r <= cnt_r + 5'h01;
        sh_r <= fr[14:0];
      end
      if (cm && fr[14:8] == 7'h0e) dead_r <= fr[7:0];
      if (cm && fr[14:8] == 7'h0f) begin
        qd_r <= fr[7:0];
        qwin_r <= 3'h6;
      end
    end
  end
  ////////////////////////////////////////////////////////////////////////////////
  reset_qst_a: assert property ($rose(rst_n_in) |-> quick_shutoff_timing_out == 8'h07)
    else $error("shutoff timing not 07 after reset");
  reset_out_a: assert property ($rose(rst_n_in) |-> !irq_out && switch_drive_out == '0)
    else $error("outputs not idle after reset");
  miso_idle_a: assert property (spi_cs_n_in [*4] |-> !spi_miso_out)
    else $error("serial out active while deselected");
  zero_dead_a: assert property (dead_r == 8'h00 && $changed(switch_request_in)
    |=> switch_drive_out == $past(switch_request_in)) else $error("code 0 did not switch at once");
  gap_start_a: assert property (dead_r != 8'h00 && $changed(switch_request_in)
    |=> switch_drive_out == '0) else $error("no break before make");
  break_make_a: assert property (dead_r != 8'h00 && $past(switch_drive_out) != '0
    && switch_drive_out != '0 |-> $stable(switch_drive_out)) else $error("make without break");
  qst_write_a: assert property (cm && fr[14:8] == 7'h0f
    |-> ##[1:5] quick_shutoff_timing_out == qd_r) else $error("shutoff write lost");
  qst_hold_a: assert property ($changed(quick_shutoff_timing_out) |-> qwin_r != 3'h0)
    else $error("shutoff timing changed without write");
  cover property (cm);
  cover property (dead_r != 8'h00 && $changed(switch_request_in));
  cover property ($rose(irq_out));
  cover property (dead_r == 8'h00 && $past(dead_r) != 8'h00);
endmodule // fmb_regs_checker

bind fmb_regs fmb_regs_checker #(.SUPPLY_W(SUPPLY_W), .NUM_SW(NUM_SW)) u_chk (
  .clk_in(clk_in), .rst_n_in(rst_n_in), .spi_clk_in(spi_clk_in), .spi_cs_n_in(spi_cs_n_in),
  .spi_mosi_in(spi_mosi_in), .spi_miso_out(spi_miso_out), .switch_request_in(switch_request_in),
  .switch_drive_out(switch_drive_out), .quick_shutoff_timing_out(quick_shutoff_timing_out),
  .irq_out(irq_out));

// ===== sim/fmb_regs_tb_top.sv
`timescale 1ns/1ps
module fmb_regs_tb_top;
  typedef struct packed {logic [6:0] a; logic [7:0] d; logic [7:0] e;} fmb_row_s;
  localparam fmb_row_s ROWS [5] = '{'{7'h0d, 8'h5a, 8'h5a}, '{7'h0e, 8'h03, 8'h03},
    '{7'h0f, 8'h3c, 8'h3c}, '{7'h0c, 8'hff, 8'h00}, '{7'h7f, 8'haa, 8'h00}};
  localparam logic [7:0] RST_V [4] = '{8'h00, 8'hf5, 8'h00, 8'h07};
  localparam logic [12:0] HV [7] = '{13'h04d3, 13'h04c4, 13'h04bd, 13'h061e, 13'h0578,
    13'h052c, 13'h1400};
  localparam logic [7:0] HE [7] = '{8'h01, 8'h01, 8'h00, 8'h03, 8'h03, 8'h01, 8'h02};
  localparam logic [7:0] DC [4] = '{8'h00, 8'h01, 8'h02, 8'hff};
  logic clk_in, rst_n_in, sck, cs_n, mosi, miso, rail, sf, ilf, pon, mmf, lbs, irq;
  logic [11:0] temp;
  logic [7:0] supply, thr, qst, rd;
  logic [2:0] req, drv;
  int n_fail = 0;
  int cmp_count = 0;
  initial clk_in = 1'b0;
  always #25 clk_in = ~clk_in;
  fmb_regs dut (.clk_in(clk_in), .rst_n_in(rst_n_in), .spi_clk_in(sck), .spi_cs_n_in(cs_n),
    .spi_mosi_in(mosi), .spi_miso_out(miso), .die_temp_in(temp),
    .internal_five_volt_rail_fault_in(rail), .input_supply_in(supply),
    .low_battery_threshold_select_in(thr), .supply_fault_in(sf), .illumination_fault_in(ilf),
    .projector_on_in(pon), .micromirror_fault_in(mmf), .low_battery_shutdown_in(lbs),
    .switch_request_in(req), .switch_drive_out(drv), .quick_shutoff_timing_out(qst),
    .irq_out(irq));
  fmb_host host (.clk_in(clk_in), .spi_miso_in(miso), .spi_clk_out(sck), .spi_cs_n_out(cs_n),
    .spi_mosi_out(mosi));
  ////////////////////////////////////////////////////////////////////////////////
  task automatic conclude();
    if (n_fail == 0 && cmp_count > 0) $display("SIMULATION PASSED");
    else $display("SIMULATION FAILED");
    $finish;
  endtask
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    cmp_count++;
    if (got !== exp) begin
      n_fail++;
      $display("wrong value at %0t: got %h, expected %h", $time, got, exp);
    end
  endtask
  task automatic chk_n(input int got, input int exp);
    cmp_count++;
    if (got != exp) begin
      n_fail++;
      $display("wrong value at %0t: %0d cycles, expected %0d", $time, got, exp);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] x;
    host.xfer({1'b1, a, d}, 16, x);
  endtask
  task automatic rdr(input logic [6:0] a, output logic [7:0] d);
    host.xfer({1'b0, a, 8'h00}, 16, d);
  endtask
  // Bit n of c raises the cause of status bit n
  task automatic cond(input logic [7:0] c);
    @(posedge clk_in);
    sf <= c[7];
    ilf <= c[6];
    pon <= !c[5];
    mmf <= c[4];
    lbs <= c[3];
    supply <= c[2] ? 8'h10 : 8'h80;
    rail <= c[1];
    temp <= c[0] ? 12'h4d3 : 12'h400;
    repeat (5) @(posedge clk_in);
  endtask
  // Counts clock cycles of settling until the drive shows pattern p
  task automatic gap(input logic [2:0] p, input logic [7:0] code);
    int n, ns, exp;
    ns = (code == 8'h00) ? 0 : 333 + 111 * (int'(code) - 1);
    exp = (code == 8'h00) ? 2 : (ns + 49) / 50 + 2;
    n = 0;
    @(posedge clk_in);
    req <= p;
    do begin
      @(negedge clk_in);
      n++;
    end while (drv !== p && n < 2000);
    if (n >= 2000) begin
      n_fail++;
      conclude();
    end
    else chk_n(n, exp);
  endtask
  ////////////////////////////////////////////////////////////////////////////////
  initial begin
    rst_n_in <= 1'b0;
    {rail, temp} <= 13'h0400;
    supply <= 8'h80;
    thr <= 8'h40;
    {sf, ilf, pon, mmf, lbs} <= 5'h04;
    req <= 3'h1;
    repeat (5) @(posedge clk_in);
    rst_n_in <= 1'b1;
    for (int i = 0; i < 4; i++) begin
      rdr(7'(12 + i), rd);
      chk(rd, RST_V[i]);
    end
    chk(qst, 8'h07);
    foreach (ROWS[k]) begin
      wr(ROWS[k].a, ROWS[k].d);
      rdr(ROWS[k].a, rd);
      chk(rd, ROWS[k].e);
    end
    chk(qst, 8'h3c);
    wr(7'h0d, 8'h00);
    for (int i = 0; i < 8; i++) begin
      cond(8'h01 << i);
      rdr(7'h0c, rd);
      chk(rd, 8'h01 << i);
      chk({7'h00, irq}, 8'h01);
      wr(7'h0d, 8'h01 << i);
      chk({7'h00, irq}, 8'h00);
      wr(7'h0d, 8'h00);
      cond(8'h00);
    end
    // Sweep through both hysteresis bands, then a rail fault while cold
    for (int k = 0; k < 7; k++) begin
      @(posedge clk_in);
      {rail, temp} <= HV[k];
      repeat (5) @(posedge clk_in);
      rdr(7'h0c, rd);
      chk(rd, HE[k]);
    end
    cond(8'h00);
    for (int k = 0; k < 4; k++) begin
      wr(7'h0e, DC[k]);
      gap((k % 2 == 1) ? 3'h4 : 3'h2, DC[k]);
    end
    // A change inside the gap restarts it
    wr(7'h0e, 8'h01);
    @(posedge clk_in);
    req <= 3'h1;
    repeat (3) @(posedge clk_in);
    gap(3'h2, 8'h01);
    // Clearing the code mid-gap ends the gap at once
    wr(7'h0e, 8'hff);
    @(posedge clk_in);
    req <= 3'h5;
    wr(7'h0e, 8'h00);
    chk({5'h00, drv}, 8'h05);
    // Aborted frame must not commit
    host.xfer({1'b1, 7'h0f, 8'h99}, 10, rd);
    rdr(7'h0f, rd);
    chk(rd, 8'h3c);
    @(posedge clk_in);
    rst_n_in <= 1'b0;
    repeat (5) @(posedge clk_in);
    rst_n_in <= 1'b1;
    rdr(7'h0d, rd);
    chk(rd, 8'hf5);
    chk(qst, 8'h07);
    conclude();
  end
endmodule // fmb_regs_tb_top
